// ===== hdl/dhp_cfg.svh
`ifndef DHP_CFG_SVH
`define DHP_CFG_SVH

// Register select codes
`define DHP_SEL_RX 1'b0
`define DHP_SEL_STATUS 1'b1

// Status nibble bit positions
`define DHP_STAT_IRQ 0
`define DHP_STAT_DSTF 1
`define DHP_STAT_TX_LO 2

// Reset value of every nibble register except the bus synchronisers, which reset to 4'hF
`define DHP_NIB_RESET 4'h0

// System clock rate
`define DHP_CLK_MHZ 40

// Crystal frequency of the tone clock, in hertz
`define DHP_XTAL_HZ 3579545

// Latch settle delay before the delayed steering flag rises
`define DHP_SETTLE_NS 1000
`define DHP_SETTLE_CYC ((`DHP_SETTLE_NS * `DHP_CLK_MHZ + 999) / 1000)

// Host bus phases, least times rounded up
`define DHP_SETUP_NS 50
`define DHP_SETUP_CYC ((`DHP_SETUP_NS * `DHP_CLK_MHZ + 999) / 1000)
`define DHP_STB_NS 250
`define DHP_STB_CYC ((`DHP_STB_NS * `DHP_CLK_MHZ + 999) / 1000)
`define DHP_HOLD_NS 100
`define DHP_HOLD_CYC ((`DHP_HOLD_NS * `DHP_CLK_MHZ + 999) / 1000)

`endif

// ===== hdl/dhp_pkg.sv
package dhp_pkg;

    // Bus style: strobe plus read/write level, or separate read and write strobes
    typedef enum logic {
        DHP_STYLE_STROBE_RW,
        DHP_STYLE_RD_WR
    } dhp_style_e;

    // One data nibble
    typedef logic [3:0] dhp_nibble_t;

endpackage

// ===== hdl/dhp_pins_if.sv
`timescale 1ns/1ps
interface dhp_pins_if;
    logic cs_n;                       // Chip select, active low, already qualified
    logic register_select_line;       // Register select
    logic access_strobe_pin;          // Data strobe or read strobe
    logic dir_pin;                    // Read/write level or write strobe
    logic [3:0] host_bus_out;         // Host drive value
    logic host_bus_oe;                // Host drives the nibble bus
    logic [3:0] dev_bus_out;          // Device drive value
    logic dev_bus_oe;                 // Device drives the nibble bus
    logic req_out;                    // Device request pin drive value
    logic req_oe;                     // Device pulls the request pin
    wire [3:0] host_nibble_bus;       // Resolved bus level
    wire request_or_progress_pin;     // Resolved open-drain level

    // Weak pull-up when nobody drives
    assign host_nibble_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 4'hF);
    assign request_or_progress_pin = req_oe ? req_out : 1'b1;

    modport dev (
        input cs_n, register_select_line, access_strobe_pin, dir_pin, host_nibble_bus,
        output dev_bus_out, dev_bus_oe, req_out, req_oe
    );

    modport host (
        output cs_n, register_select_line, access_strobe_pin, dir_pin, host_bus_out, host_bus_oe,
        input host_nibble_bus, request_or_progress_pin
    );
endinterface

// ===== hdl/dhp_device.sv
// What this block does
// - Float data bus unless a read is active
// - Host qualifies chip select with address strobe
// - Direction pin is level or write strobe
// - Access strobe toggles only during accesses; after host reset the second style's read strobe stays low one edge
// - One select line picks the register
// - Interrupt mode pulls request low on bursts
// - Call progress mode outputs in-band square wave
// - Early detect follows valid tone pair condition
// - Steering above threshold registers pair; below frees
// - Guard output depends on early detect, steering
// - Runs from crystal or external oscillator drive
// - Guard high while early detect and steering stay high
// - Latch updates on delayed steering; read presents
// - Interrupt mode: request low while flag active
`timescale 1ns/1ps
`include "dhp_cfg.svh"
module dhp_device
    import dhp_pkg::*;
#(
    parameter int SETTLE_CYC = `DHP_SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    dhp_pins_if.dev pins,
    input wire dhp_style_e bus_style,
    input wire logic irq_mode,
    input wire logic tone_pair_valid,
    input wire logic [3:0] tone_pair_code,
    input wire logic tx_burst_done,
    input wire logic [1:0] tx_status_bits,
    input wire logic cp_in_band,
    input wire logic cp_square_in,
    input wire logic steering_in,
    output logic guard_time_out,
    output logic guard_time_oe,
    output logic early_detect_out,
    input wire logic oscillator_in,
    input wire logic osc_ext_drive,
    output logic oscillator_out,
    output logic oscillator_oe,
    output logic reg_wr_pulse,
    output logic reg_wr_sel,
    output logic [3:0] reg_wr_data,
    output logic [3:0] rx_code,
    output logic dstf
);

    localparam int CW = (SETTLE_CYC > 1) ? $clog2(SETTLE_CYC) : 1;

    // Two-stage synchronisers for every pin input
    logic [1:0] cs_n_m, sel_m, stb_m, dir_m, steer_m, cp_m;
    logic [3:0] bus_m1, bus_m2;
    logic cs_n_s, sel_s, stb_s, dir_s, steer_s, cp_s;
    logic [3:0] bus_s;

    // Bus state
    logic rd_act_q;                   // Read seen last cycle
    logic wr_act_q;                   // Write seen last cycle
    logic wr_sel_q;                   // Select captured during the read or write
    logic [3:0] wr_data_q;            // Data captured during the write
    logic [3:0] rd_data_q;            // Data driven on the bus
    logic wr_pulse_q;
    logic [3:0] wr_out_q;
    logic wr_out_sel_q;

    // Receive steering state
    logic early_q;                    // Early detect output register
    logic guard_q;                    // Guard-time output register
    logic pair_reg_q;                 // Tone pair registered, waiting or done
    logic [3:0] pend_q;               // Pair captured at threshold
    logic [3:0] rx_q;                 // Receive output latch
    logic dstf_q;                     // Delayed steering flag
    logic [CW-1:0] cnt_q;             // Settle counter
    logic irq_flag_q;                 // Sticky interrupt flag
    logic req_oe_q;                   // Request pin pull

    // Synchroniser chains; only stage two is read by logic
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cs_n_m <= 2'h3;
            sel_m <= 2'h0;
            stb_m <= 2'h0;
            dir_m <= 2'h3;
            steer_m <= 2'h0;
            cp_m <= 2'h3;
            bus_m1 <= 4'hF;
            bus_m2 <= 4'hF;
        end else begin
            cs_n_m <= {cs_n_m[0], pins.cs_n};
            sel_m <= {sel_m[0], pins.register_select_line};
            stb_m <= {stb_m[0], pins.access_strobe_pin};
            dir_m <= {dir_m[0], pins.dir_pin};
            steer_m <= {steer_m[0], steering_in};
            cp_m <= {cp_m[0], cp_square_in};
            bus_m1 <= pins.host_nibble_bus;
            bus_m2 <= bus_m1;
        end
    end

    assign cs_n_s = cs_n_m[1];
    assign sel_s = sel_m[1];
    assign stb_s = stb_m[1];
    assign dir_s = dir_m[1];
    assign steer_s = steer_m[1];
    assign cp_s = cp_m[1];
    assign bus_s = bus_m2;

    // Access decode; chip select is trusted as already qualified by the host
    wire chip_sel = ~cs_n_s;
    wire style_rw = (bus_style == DHP_STYLE_STROBE_RW);
    // Strobe-and-level style reads with the data strobe high; separate style with read low
    wire rd_act = chip_sel & (style_rw ? (stb_s & dir_s) : ~stb_s);
    wire wr_act = chip_sel & (style_rw ? (stb_s & ~dir_s) : ~dir_s);
    // No strobe activity means no access; idle levels decode to nothing
    wire rd_end = rd_act_q & ~rd_act;
    wire wr_end = wr_act_q & ~wr_act;
    wire status_rd_end = rd_end & (wr_sel_q == `DHP_SEL_STATUS);

    // Read mux: select line chooses receive latch or status
    wire [3:0] status_nib = {tx_status_bits, dstf_q, irq_flag_q};
    wire [3:0] rd_mux = (sel_s == `DHP_SEL_STATUS) ? status_nib : rx_q;

    // Bus tracking and write capture
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_act_q <= 1'b0;
            wr_act_q <= 1'b0;
            wr_sel_q <= 1'b0;
            wr_data_q <= `DHP_NIB_RESET;
            rd_data_q <= `DHP_NIB_RESET;
        end else begin
            rd_act_q <= rd_act;
            wr_act_q <= wr_act;
            if (rd_act | wr_act) begin
                wr_sel_q <= sel_s;
            end
            if (wr_act) begin
                wr_data_q <= bus_s;
            end
            if (rd_act) begin
                rd_data_q <= rd_mux;
            end
        end
    end

    // Write pulse at the end of the strobe, using values held during it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wr_pulse_q <= 1'b0;
            wr_out_q <= `DHP_NIB_RESET;
            wr_out_sel_q <= 1'b0;
        end else begin
            wr_pulse_q <= wr_end;
            if (wr_end) begin
                wr_out_q <= wr_data_q;
                wr_out_sel_q <= wr_sel_q;
            end
        end
    end

    // Drive only while a read is decoded; enable rises one cycle past the sync depth, falls after it
    assign pins.dev_bus_oe = rd_act_q & rd_act;
    assign pins.dev_bus_out = rd_data_q;

    // Early detect follows the detector's signal condition, any drop clears it
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            early_q <= 1'b0;
        end else begin
            early_q <= tone_pair_valid;
        end
    end

    // Guard output charges the RC while a pair holds and steering is high
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            guard_q <= 1'b0;
        end else begin
            guard_q <= early_q & (steer_s | pair_reg_q);
        end
    end

    // Steering: register at threshold, wait settle delay, then raise the flag
    wire settle_done = pair_reg_q & ~dstf_q & (cnt_q == CW'(SETTLE_CYC - 1));
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pair_reg_q <= 1'b0;
            pend_q <= `DHP_NIB_RESET;
            rx_q <= `DHP_NIB_RESET;
            dstf_q <= 1'b0;
            cnt_q <= '0;
        end else if (!steer_s) begin
            // Below threshold the receiver is free for a new pair
            pair_reg_q <= 1'b0;
            dstf_q <= 1'b0;
            cnt_q <= '0;
        end else if (!pair_reg_q) begin
            pair_reg_q <= 1'b1;
            pend_q <= tone_pair_code;
            cnt_q <= '0;
        end else if (settle_done) begin
            // Latch moves only on the flag's rising edge, so a read never sees a half-settled code
            dstf_q <= 1'b1;
            rx_q <= pend_q;
        end else if (!dstf_q) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // Sticky interrupt flag; a new event beats a clearing status read
    wire irq_set = settle_done | tx_burst_done;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_flag_q <= 1'b0;
        end else if (irq_set) begin
            irq_flag_q <= 1'b1;
        end else if (status_rd_end) begin
            irq_flag_q <= 1'b0;
        end
    end

    // Request pin: interrupt pull, or in-band square wave in call progress mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            req_oe_q <= 1'b0;
        end else if (irq_mode) begin
            req_oe_q <= irq_flag_q | dstf_q;
        end else begin
            // Out of band the pin is released; in band it pulls while the signal is low
            req_oe_q <= cp_in_band & ~cp_s;
        end
    end

    assign pins.req_out = 1'b0;
    assign pins.req_oe = req_oe_q;

    // Crystal inverter; released when the oscillator input is driven externally
    assign oscillator_out = ~oscillator_in;
    assign oscillator_oe = ~osc_ext_drive;

    assign early_detect_out = early_q;
    assign guard_time_out = guard_q;
    assign guard_time_oe = 1'b1;
    assign reg_wr_pulse = wr_pulse_q;
    assign reg_wr_sel = wr_out_sel_q;
    assign reg_wr_data = wr_out_q;
    assign rx_code = rx_q;
    assign dstf = dstf_q;

endmodule

// ===== hdl/dhp_host.sv
`timescale 1ns/1ps
`include "dhp_cfg.svh"
module dhp_host
    import dhp_pkg::*;
#(
    parameter int SETUP_CYC = `DHP_SETUP_CYC,
    parameter int STB_CYC = `DHP_STB_CYC,
    parameter int HOLD_CYC = `DHP_HOLD_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    dhp_pins_if.host pins,
    input wire dhp_style_e bus_style,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_sel,
    input wire logic [3:0] req_data,
    output logic done,
    output logic [3:0] rd_data,
    output logic irq_level
);

    // Access phases
    typedef enum logic [1:0] {
        DHP_IDLE,
        DHP_SETUP,
        DHP_STROBE,
        DHP_HOLD
    } dhp_hst_e;

    dhp_hst_e state_q;
    logic [7:0] cnt_q;                // Phase counter
    logic wr_q;                       // Current access is a write
    logic addr_valid_q;               // Own address strobe, gates chip select
    logic sel_q, stb_q, dir_q, boe_q, done_q;
    logic [3:0] bout_q, rd_q;
    logic [3:0] bus_m1, bus_m2;       // Read data synchroniser
    logic [1:0] req_m;                // Request pin synchroniser

    wire style_rw = (bus_style == DHP_STYLE_STROBE_RW);
    wire phase_end = (cnt_q == 8'h00);
    // Idle strobe level: strobe low in first style, read high in second
    wire stb_idle = ~style_rw;

    // Pin synchronisers; only the second stage is read
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bus_m1 <= 4'hF;
            bus_m2 <= 4'hF;
            req_m <= 2'h3;
        end else begin
            bus_m1 <= pins.host_nibble_bus;
            bus_m2 <= bus_m1;
            req_m <= {req_m[0], pins.request_or_progress_pin};
        end
    end

    // Access sequencer: setup, strobe, hold; one access at a time
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= DHP_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            addr_valid_q <= 1'b0;
            sel_q <= 1'b0;
            stb_q <= 1'b0;
            dir_q <= 1'b1;
            boe_q <= 1'b0;
            bout_q <= `DHP_NIB_RESET;
            rd_q <= `DHP_NIB_RESET;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                DHP_IDLE: begin
                    stb_q <= stb_idle;
                    if (req_valid) begin
                        wr_q <= req_write;
                        sel_q <= req_sel;
                        bout_q <= req_data;
                        boe_q <= req_write;
                        addr_valid_q <= 1'b1;
                        // First style: direction is a level set before the strobe
                        dir_q <= ~(style_rw & req_write);
                        cnt_q <= 8'(SETUP_CYC - 1);
                        state_q <= DHP_SETUP;
                    end
                end
                DHP_SETUP: begin
                    if (phase_end) begin
                        if (style_rw) begin
                            stb_q <= 1'b1;
                        end else if (wr_q) begin
                            dir_q <= 1'b0;
                        end else begin
                            stb_q <= 1'b0;
                        end
                        cnt_q <= 8'(STB_CYC - 1);
                        state_q <= DHP_STROBE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                DHP_STROBE: begin
                    if (phase_end) begin
                        // Sample read data at the last strobe cycle, after sync latency
                        rd_q <= bus_m2;
                        stb_q <= stb_idle;
                        if (!style_rw) begin
                            dir_q <= 1'b1;
                        end
                        cnt_q <= 8'(HOLD_CYC - 1);
                        state_q <= DHP_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                DHP_HOLD: begin
                    // Data and select held past the strobe so the device sees them settle
                    if (phase_end) begin
                        addr_valid_q <= 1'b0;
                        boe_q <= 1'b0;
                        dir_q <= 1'b1;
                        done_q <= 1'b1;
                        state_q <= DHP_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q <= DHP_IDLE;
                end
            endcase
        end
    end

    // Chip select only while the own address strobe marks a valid cycle
    assign pins.cs_n = ~addr_valid_q;
    assign pins.register_select_line = sel_q;
    assign pins.access_strobe_pin = stb_q;
    assign pins.dir_pin = dir_q;
    assign pins.host_bus_out = bout_q;
    assign pins.host_bus_oe = boe_q;

    assign req_ready = (state_q == DHP_IDLE);
    assign done = done_q;
    assign rd_data = rd_q;
    assign irq_level = ~req_m[1];

endmodule

// ===== sim/dhp_pins_assertions.sv
`timescale 1ns/1ps
module dhp_pins_assertions
    import dhp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire dhp_style_e bus_style,
    input wire logic cs_n,
    input wire logic register_select_line,
    input wire logic access_strobe_pin,
    input wire logic dir_pin,
    input wire logic [3:0] host_bus_out,
    input wire logic host_bus_oe,
    input wire logic dev_bus_oe,
    input wire logic req_out,
    input wire logic req_oe
);
    // Strobe at its active level for the style in use
    wire strobe_act = (bus_style == DHP_STYLE_STROBE_RW) ? access_strobe_pin : !access_strobe_pin;
    // Read as seen at the pins; the read strobe style ignores the direction pin
    wire read_act = !cs_n && strobe_act && ((bus_style == DHP_STYLE_RD_WR) || dir_pin);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Chip select and read strobe both seen three edges back, the device's sync and decode depth
    property p_float_cs; dev_bus_oe |-> $past(cs_n, 3) == 1'b0 && $past(read_act, 3); endproperty
    a_float_cs: assert property (p_float_cs) else $error("bus driven without chip select");
    property p_no_fight; dev_bus_oe |-> !host_bus_oe; endproperty
    a_no_fight: assert property (p_no_fight) else $error("both ends drive the bus");
    property p_oe_rise; $rose(read_act) |-> ##[2:6] dev_bus_oe; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("read not answered");
    property p_oe_fall; $fell(read_act) |-> ##[1:5] !dev_bus_oe; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("bus not floated after read");
    // Reset leaves the read strobe low for one edge in the second style, hence the past term
    property p_strobe_in_access; strobe_act && !$past(rst) |-> !cs_n; endproperty
    a_strobe_in_access: assert property (p_strobe_in_access) else $error("strobe outside access");
    property p_cs_len; $fell(cs_n) |-> (!cs_n) [*8] ##1 (!cs_n) [*8] ##1 cs_n; endproperty
    a_cs_len: assert property (p_cs_len) else $error("access length wrong");
    property p_wr_strobe; bus_style == DHP_STYLE_RD_WR && !dir_pin |-> !cs_n && host_bus_oe; endproperty
    a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe outside write");
    property p_rw_level; bus_style == DHP_STYLE_STROBE_RW && host_bus_oe |-> !dir_pin; endproperty
    a_rw_level: assert property (p_rw_level) else $error("write without write level");
    property p_sel_hold; !cs_n && !$past(cs_n) |-> $stable(register_select_line); endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved in access");
    property p_data_hold; host_bus_oe && $past(host_bus_oe) |-> $stable(host_bus_out); endproperty
    a_data_hold: assert property (p_data_hold) else $error("write data moved");
    property p_open_drain; req_oe |-> req_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("request pin driven high");
endmodule

// ===== sim/dtmf_host_port_and_steering_bench.sv
`timescale 1ns/1ps
module dtmf_host_port_and_steering_bench;
    import dhp_pkg::*;
    logic clk_sys = 1'b0; // 40 MHz system clock
    logic rst = 1'b1; // Asynchronous reset, active high
    dhp_style_e bus_style = DHP_STYLE_STROBE_RW; // Both ends must agree
    logic irq_mode = 1'b1;
    logic tone_pair_valid = 1'b0;
    logic [3:0] tone_pair_code = 4'h0;
    logic tx_burst_done = 1'b0;
    logic [1:0] tx_status_bits = 2'h0;
    logic cp_in_band = 1'b0;
    logic cp_square_in = 1'b0;
    logic steering_in = 1'b0; // Threshold result, high above threshold
    logic oscillator_in = 1'b0;
    logic osc_ext_drive = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_sel = 1'b0;
    logic [3:0] req_data = 4'h0;
    logic req_ready, done, irq_level, guard_time_out, guard_time_oe, early_detect_out;
    logic oscillator_out, oscillator_oe, reg_wr_pulse, reg_wr_sel, dstf;
    logic [3:0] rd_data, reg_wr_data, rx_code;
    int failures = 0;
    int compares = 0;
    int wr_cnt = 0; // Write pulses seen on the register side

    dhp_pins_if dhp_pins_if_i ();
    dhp_host dhp_host_i (.clk_sys, .rst, .pins(dhp_pins_if_i), .bus_style, .req_valid, .req_ready, .req_write,
        .req_sel, .req_data, .done, .rd_data, .irq_level);
    // Short settle count keeps the steering tests brief
    dhp_device #(.SETTLE_CYC(3)) dhp_device_i (.clk_sys, .rst, .pins(dhp_pins_if_i), .bus_style, .irq_mode,
        .tone_pair_valid, .tone_pair_code, .tx_burst_done, .tx_status_bits, .cp_in_band, .cp_square_in,
        .steering_in, .guard_time_out, .guard_time_oe, .early_detect_out, .oscillator_in, .osc_ext_drive,
        .oscillator_out, .oscillator_oe, .reg_wr_pulse, .reg_wr_sel, .reg_wr_data, .rx_code, .dstf);
    dhp_pins_assertions dhp_pins_assertions_i (.clk_sys, .rst, .bus_style, .cs_n(dhp_pins_if_i.cs_n),
        .register_select_line(dhp_pins_if_i.register_select_line),
        .access_strobe_pin(dhp_pins_if_i.access_strobe_pin), .dir_pin(dhp_pins_if_i.dir_pin),
        .host_bus_out(dhp_pins_if_i.host_bus_out), .host_bus_oe(dhp_pins_if_i.host_bus_oe),
        .dev_bus_oe(dhp_pins_if_i.dev_bus_oe), .req_out(dhp_pins_if_i.req_out), .req_oe(dhp_pins_if_i.req_oe));

    // Free running clock
    always #12.5 clk_sys = ~clk_sys;

    // Count write pulses so a missing or doubled one shows
    always @(posedge clk_sys) if (reg_wr_pulse === 1'b1) wr_cnt <= wr_cnt + 1;

    // Expected status nibble
    function automatic logic [3:0] exp_status(input logic [1:0] tx, input logic ds, input logic irq);
        return {tx, ds, irq};
    endfunction

    task automatic give_verdict();
        $display("counts: %0d compares, %0d failures", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // A bound that ran out ends the run as a failure
    task automatic ran_out(input string what);
        failures++;
        $display("mismatch %s expected completion seen timeout", what);
        give_verdict();
    endtask

    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // One host access; a write also checks what reached the register side
    task automatic access(input logic w, input logic s, input logic [3:0] d);
        int n;
        int c0;
        c0 = wr_cnt;
        tick(1);
        req_valid = 1'b1;
        req_write = w;
        req_sel = s;
        req_data = d;
        tick(1);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1) begin
            tick(1);
            n++;
            if (n > 40) ran_out("done");
        end
        chk("idle bus", 4'hF, dhp_pins_if_i.host_nibble_bus);
        chk("cs idle", 4'h1, {3'h0, dhp_pins_if_i.cs_n});
        chk("strobe idle", {3'h0, bus_style == DHP_STYLE_RD_WR}, {3'h0, dhp_pins_if_i.access_strobe_pin});
        chk("ready", 4'h1, {3'h0, req_ready});
        n = 0;
        while (w && wr_cnt == c0) begin
            tick(1);
            n++;
            if (n > 8) ran_out("write pulse");
        end
        if (w) begin
            chk("write count", 4'h1, 4'(wr_cnt - c0));
            chk("write sel", {3'h0, s}, {3'h0, reg_wr_sel});
            chk("write data", d, reg_wr_data);
        end
    endtask

    // Tone pair registration, latch read, status read and release
    task automatic rx_test(input logic [3:0] code);
        int n;
        irq_mode = 1'b1;
        tx_status_bits = 2'($urandom);
        tone_pair_code = code;
        tone_pair_valid = 1'b1;
        tick(1);
        chk("early", 4'h1, {3'h0, early_detect_out});
        tick(1);
        chk("guard low", 4'h0, {3'h0, guard_time_out});
        steering_in = 1'b1;
        n = 0;
        while (dstf !== 1'b1) begin
            tick(1);
            n++;
            if (n > 20) ran_out("dstf");
        end
        chk("rx code", code, rx_code);
        chk("guard high", 4'h1, {3'h0, guard_time_out});
        tick(4);
        chk("irq", 4'h1, {3'h0, irq_level});
        access(1'b0, 1'b0, 4'h0);
        chk("rx read", code, rd_data);
        access(1'b0, 1'b1, 4'h0);
        chk("status", exp_status(tx_status_bits, 1'b1, 1'b1), rd_data);
        tone_pair_valid = 1'b0;
        tick(3);
        chk("early off", 4'h0, {3'h0, early_detect_out});
        chk("guard off", 4'h0, {3'h0, guard_time_out});
        steering_in = 1'b0;
        tick(6);
        chk("dstf off", 4'h0, {3'h0, dstf});
        chk("irq off", 4'h0, {3'h0, irq_level});
    endtask

    initial begin
        void'($urandom(10));
        for (int k = 0; k < 2; k++) begin
            // Style changes only under reset, a second reset mid-run
            rst = 1'b1;
            bus_style = dhp_style_e'(k);
            tick(2);
            rst = 1'b0;
            tick(2);
            access(1'b1, 1'b1, 4'hF);
            access(1'b1, 1'b0, 4'h0);
            repeat (6) access(1'b1, 1'($urandom), 4'($urandom));
            rx_test(4'($urandom));
            rx_test(4'h0);
            // Transmit burst raises the request, a status read clears it
            tx_burst_done = 1'b1;
            tick(1);
            tx_burst_done = 1'b0;
            tick(5);
            chk("tx irq", 4'h1, {3'h0, irq_level});
            access(1'b0, 1'b1, 4'h0);
            chk("tx status", exp_status(tx_status_bits, 1'b0, 1'b1), rd_data);
            tick(5);
            chk("tx irq off", 4'h0, {3'h0, irq_level});
            // Call progress: pin follows the square wave only in band
            irq_mode = 1'b0;
            for (int i = 0; i < 8; i++) begin
                cp_in_band = (i < 6);
                cp_square_in = 1'($urandom);
                tick(8);
                chk("progress", {3'h0, cp_in_band & ~cp_square_in}, {3'h0, irq_level});
            end
            cp_in_band = 1'b0;
            $display("test style %0d finished", k);
        end
        // Oscillator pins as modelled inverter and drive enable
        for (int i = 0; i < 4; i++) begin
            oscillator_in = 1'(i);
            osc_ext_drive = 1'($urandom);
            #1;
            chk("osc out", {3'h0, ~oscillator_in}, {3'h0, oscillator_out});
            chk("osc oe", {3'h0, ~osc_ext_drive}, {3'h0, oscillator_oe});
            tick(1);
        end
        chk("guard oe", 4'h1, {3'h0, guard_time_oe});
        $display("test oscillator finished");
        give_verdict();
    end
endmodule
